//--- rtl/regs_cfg.svh
// Notes on behaviour
// - low init address register and its alias share one storage.
// - init address registers are read/write and ignore all resets and stop.
// - with 32-bit structures the high byte tops only the init address.
// - with 16-bit structures the high byte is prepended to every 24-bit address.
// - with 16-bit structures on-chip address top bytes become the high byte.
// - each write to the high init register also updates its alias.
// - init address bits 23-16 come from high register bits 7-0.
// - receive mask blocks receive flag from summary; hw reset sets, sw reset clears.
// - transmit mask blocks transmit flag; hw reset sets, sw reset clears.
// - init-done mask blocks init-done flag; both resets clear it.
// - writes to obsolete bits 12, 11 and 6 are ignored.
// - reserved bits 15-13, 7 and 31-16 read zero.
// - look-ahead raises receive interrupt after first and last descriptor writes.
// - look-ahead begins each packet at a start-marked descriptor.
// - after last descriptor, scan following entries whatever their ownership.
// - scanned device-held unmarked entries get ownership cleared; host-held skipped.
// - marked host-held entry stops the scan and is polled periodically.
// - marked device-held entry stops the scan and waits for the next frame.
// - look-ahead enable cleared by both resets, kept by stop.
// - bit 4 disables two-part deferral; both resets clear it.
// - bit 3 selects modified back-off; both resets clear it.
// - receive flag cleared by writing one; writing zero does nothing.
// - interrupt output active when summary flag and global enable are set.
`ifndef REGS_CFG_SVH
`define REGS_CFG_SVH
// ****************************************
// register byte addresses
// ****************************************
`define ADR_CTRL 8'h00
`define ADR_INIT_LO 8'h04
`define ADR_INIT_HI 8'h08
`define ADR_MASK 8'h0c
`define ADR_STATUS 8'h10
`define ADR_LO_ALIAS 8'h40
`define ADR_HI_ALIAS 8'h44
// ****************************************
// field positions
// ****************************************
`define B_STOP 0
`define B_SRST 1
`define B_SS32 2
`define B_GIE 3
`define B_RX_MASK 10
`define B_TX_MASK 9
`define B_ID_MASK 8
`define B_LAPP 5
`define B_DX2PD 4
`define B_MBO 3
`define B_RX_FLAG 10
`define B_TX_FLAG 9
`define B_ID_FLAG 8
`define B_SUM_FLAG 7
// ****************************************
// reset values and responses
// ****************************************
`define RST_RX_MASK 1'b1
`define RST_TX_MASK 1'b1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// ****************************************
// timing
// ****************************************
`define CLK_NS 25
`define POLL_TIME_NS 1000
`define POLL_CYCLES ((`POLL_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- rtl/regs_pkg.sv
package regs_pkg;
	typedef enum logic [2:0] {
		SC_IDLE = 3'b000,
		SC_READ = 3'b001,
		SC_EVAL = 3'b010,
		SC_CLEAR = 3'b011,
		SC_POLL = 3'b100,
		SC_HOLD = 3'b101
	} scan_state_t;
endpackage

//--- rtl/init_addr_and_interrupt_mask_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "regs_cfg.svh"
module init_addr_and_interrupt_mask_regs import regs_pkg::*; #(
	parameter int RING_AW = 7,
	parameter int POLL_CYC = `POLL_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// events
	input wire logic rx_first_desc_wr_i,
	input wire logic rx_last_desc_wr_i,
	input wire logic tx_done_i,
	input wire logic init_done_i,
	output logic interrupt_output_o,
	// configuration
	output logic [31:0] init_block_address_o,
	output logic software_struct_32bit_o,
	output logic lookahead_enable_o,
	output logic disable_two_part_deferral_o,
	output logic modified_backoff_enable_o,
	// bus master address formation
	input wire logic [31:0] bm_addr_raw_i,
	input wire logic bm_addr_valid_i,
	output logic [31:0] bm_addr_o,
	output logic bm_addr_valid_o,
	// start-of-packet scan
	input wire logic [RING_AW-1:0] ring_last_i,
	output logic [RING_AW-1:0] ring_index_o,
	output logic desc_rd_req_o,
	input wire logic desc_rd_done_i,
	input wire logic desc_own_i,
	input wire logic desc_sop_i,
	output logic desc_clr_own_o,
	input wire logic desc_wr_done_i,
	output logic scan_hold_o,
	input wire logic frame_start_i
);
	// ****************************************
	// parameter checks
	// ****************************************
	if (RING_AW < 1 || RING_AW > 16) begin : g_bad_aw
		$error("RING_AW out of range");
	end
	if (POLL_CYC < 1 || POLL_CYC > 65535) begin : g_bad_poll
		$error("POLL_CYC out of range");
	end

	// ****************************************
	// axi write channel
	// ****************************************
	logic aw_got_reg, w_got_reg, awready_reg, wready_reg, bvalid_reg;
	logic [1:0] bresp_reg;
	logic [7:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_got_next, w_got_next;
	wire aw_take_w = s_axi_awvalid_i & awready_reg;
	wire w_take_w = s_axi_wvalid_i & wready_reg;
	wire wr_fire_w = aw_got_reg & w_got_reg & ~bvalid_reg;
	wire wr_ctrl_w = wr_fire_w & (waddr_reg == `ADR_CTRL);
	wire wr_lo_w = wr_fire_w & ((waddr_reg == `ADR_INIT_LO) | (waddr_reg == `ADR_LO_ALIAS));
	wire wr_hi_w = wr_fire_w & (waddr_reg == `ADR_INIT_HI);
	wire wr_hia_w = wr_fire_w & (waddr_reg == `ADR_HI_ALIAS);
	wire wr_mask_w = wr_fire_w & (waddr_reg == `ADR_MASK);
	wire wr_stat_w = wr_fire_w & (waddr_reg == `ADR_STATUS);
	wire wr_hit_w = wr_ctrl_w | wr_lo_w | wr_hi_w | wr_hia_w | wr_mask_w | wr_stat_w;
	wire stop_w = wr_ctrl_w & wstrb_reg[0] & wdata_reg[`B_STOP];
	wire srst_w = wr_ctrl_w & wstrb_reg[0] & wdata_reg[`B_SRST];

	always_comb begin
		aw_got_next = wr_fire_w ? 1'b0 : (aw_got_reg | aw_take_w);
		w_got_next = wr_fire_w ? 1'b0 : (w_got_reg | w_take_w);
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			awready_reg <= ~aw_got_next & ~(bvalid_reg & ~s_axi_bready_i);
			wready_reg <= ~w_got_next & ~(bvalid_reg & ~s_axi_bready_i);
			if (aw_take_w) begin
				waddr_reg <= {s_axi_awaddr_i[7:2], 2'b00};
			end
			if (w_take_w) begin
				wdata_reg <= s_axi_wdata_i;
				wstrb_reg <= s_axi_wstrb_i;
			end
			if (wr_fire_w) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit_w ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// ****************************************
	// init block address storage
	// ****************************************
	// no reset here: contents must survive every reset and stop
	logic [15:0] init_lo_reg, init_hi_reg, init_hia_reg;
	always_ff @(posedge ref_clk_i) begin
		if (wr_lo_w) begin
			init_lo_reg <= merge16(init_lo_reg, wdata_reg, wstrb_reg);
		end
		if (wr_hi_w) begin
			init_hi_reg <= merge16(init_hi_reg, wdata_reg, wstrb_reg);
		end
		if (wr_hi_w) begin
			init_hia_reg <= merge16(init_hi_reg, wdata_reg, wstrb_reg);
		end else if (wr_hia_w) begin
			init_hia_reg <= merge16(init_hia_reg, wdata_reg, wstrb_reg);
		end
	end
	wire [7:0] high_byte_w = init_hi_reg[15:8];
	wire [31:0] init_addr_w = {high_byte_w, init_hi_reg[7:0], init_lo_reg};

	// ****************************************
	// control, masks and options
	// ****************************************
	logic ss32_reg, gie_reg;
	logic rx_mask_reg, tx_mask_reg, id_mask_reg, lapp_reg, dx2pd_reg, mbo_reg;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ss32_reg <= 1'b0;
			gie_reg <= 1'b0;
			rx_mask_reg <= `RST_RX_MASK;
			tx_mask_reg <= `RST_TX_MASK;
			id_mask_reg <= 1'b0;
			lapp_reg <= 1'b0;
			dx2pd_reg <= 1'b0;
			mbo_reg <= 1'b0;
		end else if (srst_w) begin
			ss32_reg <= 1'b0;
			gie_reg <= 1'b0;
			rx_mask_reg <= 1'b0;
			tx_mask_reg <= 1'b0;
			id_mask_reg <= 1'b0;
			lapp_reg <= 1'b0;
			dx2pd_reg <= 1'b0;
			mbo_reg <= 1'b0;
		end else begin
			if (stop_w) begin
				gie_reg <= 1'b0;
			end else if (wr_ctrl_w & wstrb_reg[0]) begin
				gie_reg <= wdata_reg[`B_GIE];
			end
			if (wr_ctrl_w & wstrb_reg[0]) begin
				ss32_reg <= wdata_reg[`B_SS32];
			end
			// obsolete bits 12, 11, 6 have no storage at all
			if (wr_mask_w & wstrb_reg[1]) begin
				rx_mask_reg <= wdata_reg[`B_RX_MASK];
				tx_mask_reg <= wdata_reg[`B_TX_MASK];
				id_mask_reg <= wdata_reg[`B_ID_MASK];
			end
			if (wr_mask_w & wstrb_reg[0]) begin
				lapp_reg <= wdata_reg[`B_LAPP];
				dx2pd_reg <= wdata_reg[`B_DX2PD];
				mbo_reg <= wdata_reg[`B_MBO];
			end
		end
	end

	// ****************************************
	// interrupt flags and summary
	// ****************************************
	logic rx_flag_reg, tx_flag_reg, id_flag_reg, irq_reg;
	wire clr_byte_w = wr_stat_w & wstrb_reg[1];
	wire rx_clr_w = clr_byte_w & wdata_reg[`B_RX_FLAG];
	wire tx_clr_w = clr_byte_w & wdata_reg[`B_TX_FLAG];
	wire id_clr_w = clr_byte_w & wdata_reg[`B_ID_FLAG];
	wire rx_ev_w = rx_last_desc_wr_i | (lapp_reg & rx_first_desc_wr_i);
	wire summary_w = (rx_flag_reg & ~rx_mask_reg) | (tx_flag_reg & ~tx_mask_reg)
		| (id_flag_reg & ~id_mask_reg);
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_flag_reg <= 1'b0;
			tx_flag_reg <= 1'b0;
			id_flag_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			if (srst_w | stop_w) begin
				rx_flag_reg <= 1'b0;
				tx_flag_reg <= 1'b0;
				id_flag_reg <= 1'b0;
			end else begin
				// an event in the clearing cycle is kept
				rx_flag_reg <= rx_ev_w | (rx_flag_reg & ~rx_clr_w);
				tx_flag_reg <= tx_done_i | (tx_flag_reg & ~tx_clr_w);
				id_flag_reg <= init_done_i | (id_flag_reg & ~id_clr_w);
			end
			irq_reg <= summary_w & gie_reg;
		end
	end

	// ****************************************
	// bus master address formation
	// ****************************************
	logic [31:0] bm_addr_reg, init_out_reg;
	logic bm_valid_reg;
	wire [31:0] bm_fixed_w = software_struct_32bit_o ? bm_addr_raw_i
		: {high_byte_w, bm_addr_raw_i[23:0]};
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bm_addr_reg <= 32'h0000_0000;
			bm_valid_reg <= 1'b0;
			init_out_reg <= 32'h0000_0000;
		end else begin
			bm_valid_reg <= bm_addr_valid_i;
			if (bm_addr_valid_i) begin
				bm_addr_reg <= bm_fixed_w;
			end
			init_out_reg <= init_addr_w;
		end
	end

	// ****************************************
	// start-of-packet scan
	// ****************************************
	// one ring entry per read; a long skipped run costs one read each
	scan_state_t st_reg, st_next;
	logic [RING_AW-1:0] idx_reg, idx_next;
	logic [15:0] poll_reg, poll_next;
	logic rd_reg, rd_next, clr_reg, clr_next, hold_reg, hold_next;
	wire [RING_AW-1:0] idx_inc_w = (idx_reg == ring_last_i) ? '0
		: idx_reg + {{(RING_AW-1){1'b0}}, 1'b1};
	logic own_q_reg, sop_q_reg;

	always_comb begin
		st_next = st_reg;
		idx_next = idx_reg;
		poll_next = poll_reg;
		rd_next = 1'b0;
		clr_next = 1'b0;
		hold_next = 1'b0;
		case (st_reg)
			SC_IDLE: begin
				if (lapp_reg & rx_last_desc_wr_i) begin
					idx_next = idx_inc_w;
					st_next = SC_READ;
					rd_next = 1'b1;
				end
			end
			SC_READ: begin
				rd_next = ~desc_rd_done_i;
				if (desc_rd_done_i) begin
					st_next = SC_EVAL;
				end
			end
			SC_EVAL: begin
				if (sop_q_reg & own_q_reg) begin
					st_next = SC_HOLD;
					hold_next = 1'b1;
				end else if (sop_q_reg) begin
					st_next = SC_POLL;
					poll_next = 16'(POLL_CYC - 1);
				end else if (own_q_reg) begin
					st_next = SC_CLEAR;
					clr_next = 1'b1;
				end else begin
					idx_next = idx_inc_w;
					st_next = SC_READ;
					rd_next = 1'b1;
				end
			end
			SC_CLEAR: begin
				clr_next = ~desc_wr_done_i;
				if (desc_wr_done_i) begin
					idx_next = idx_inc_w;
					st_next = SC_READ;
					rd_next = 1'b1;
				end
			end
			SC_POLL: begin
				if (poll_reg == 16'h0000) begin
					st_next = SC_READ;
					rd_next = 1'b1;
				end else begin
					poll_next = poll_reg - 16'h0001;
				end
			end
			SC_HOLD: begin
				hold_next = ~frame_start_i;
				if (frame_start_i) begin
					st_next = SC_IDLE;
				end
			end
			default: begin
				st_next = SC_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= SC_IDLE;
			idx_reg <= '0;
			poll_reg <= 16'h0000;
			rd_reg <= 1'b0;
			clr_reg <= 1'b0;
			hold_reg <= 1'b0;
			own_q_reg <= 1'b0;
			sop_q_reg <= 1'b0;
		end else if (srst_w | stop_w) begin
			st_reg <= SC_IDLE;
			idx_reg <= '0;
			rd_reg <= 1'b0;
			clr_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			idx_reg <= idx_next;
			poll_reg <= poll_next;
			rd_reg <= rd_next;
			clr_reg <= clr_next;
			hold_reg <= hold_next;
			if (st_reg == SC_READ && desc_rd_done_i) begin
				own_q_reg <= desc_own_i;
				sop_q_reg <= desc_sop_i;
			end
		end
	end

	// ****************************************
	// axi read channel
	// ****************************************
	logic arready_reg, rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	wire [7:0] ra_w = {s_axi_araddr_i[7:2], 2'b00};
	wire [31:0] rd_ctrl_w = {28'h0000000, gie_reg, ss32_reg, 2'b00};
	wire [31:0] rd_mask_w = {16'h0000, 5'h00, rx_mask_reg, tx_mask_reg, id_mask_reg,
		2'b00, lapp_reg, dx2pd_reg, mbo_reg, 3'b000};
	wire [31:0] rd_stat_w = {16'h0000, 5'h00, rx_flag_reg, tx_flag_reg, id_flag_reg,
		summary_w, 7'h00};
	wire rd_hit_w = (ra_w == `ADR_CTRL) | (ra_w == `ADR_INIT_LO) | (ra_w == `ADR_INIT_HI)
		| (ra_w == `ADR_MASK) | (ra_w == `ADR_STATUS) | (ra_w == `ADR_LO_ALIAS)
		| (ra_w == `ADR_HI_ALIAS);
	wire [31:0] rd_word_w =
		(ra_w == `ADR_CTRL) ? rd_ctrl_w :
		((ra_w == `ADR_INIT_LO) | (ra_w == `ADR_LO_ALIAS)) ? {16'h0000, init_lo_reg} :
		(ra_w == `ADR_INIT_HI) ? {16'h0000, init_hi_reg} :
		(ra_w == `ADR_HI_ALIAS) ? {16'h0000, init_hia_reg} :
		(ra_w == `ADR_MASK) ? rd_mask_w :
		(ra_w == `ADR_STATUS) ? rd_stat_w : 32'h0000_0000;
	wire ar_take_w = s_axi_arvalid_i & arready_reg;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `RESP_OKAY;
		end else if (ar_take_w) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word_w;
			rresp_reg <= rd_hit_w ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_reg & s_axi_rready_i) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end else if (~rvalid_reg) begin
			arready_reg <= 1'b1;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready_o = awready_reg;
	assign s_axi_wready_o = wready_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_arready_o = arready_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;
	assign interrupt_output_o = irq_reg;
	assign init_block_address_o = init_out_reg;
	assign software_struct_32bit_o = ss32_reg;
	assign lookahead_enable_o = lapp_reg;
	assign disable_two_part_deferral_o = dx2pd_reg;
	assign modified_backoff_enable_o = mbo_reg;
	assign bm_addr_o = bm_addr_reg;
	assign bm_addr_valid_o = bm_valid_reg;
	assign ring_index_o = idx_reg;
	assign desc_rd_req_o = rd_reg;
	assign desc_clr_own_o = clr_reg;
	assign scan_hold_o = hold_reg;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_eval_own_sop;
		st_reg == SC_EVAL && own_q_reg && sop_q_reg && !srst_w && !stop_w;
	endsequence
	sequence s_hold_wait;
		scan_hold_o && st_reg == SC_HOLD;
	endsequence

	AST_LO_ALIAS: assert property (ar_take_w && ra_w == `ADR_LO_ALIAS |=>
		s_axi_rdata_o[15:0] == init_lo_reg) else $error("low alias differs");
	AST_HI_COPY: assert property (wr_hi_w |=> init_hia_reg == init_hi_reg)
		else $error("high alias not copied");
	AST_RX_MASK: assert property (rx_flag_reg && rx_mask_reg
		&& !(tx_flag_reg && !tx_mask_reg) && !(id_flag_reg && !id_mask_reg)
		|=> !interrupt_output_o) else $error("rx mask leak");
	AST_TX_MASK: assert property (tx_flag_reg && tx_mask_reg
		&& !(rx_flag_reg && !rx_mask_reg) && !(id_flag_reg && !id_mask_reg)
		|=> !interrupt_output_o) else $error("tx mask leak");
	AST_ID_MASK: assert property (id_flag_reg && id_mask_reg
		&& !(rx_flag_reg && !rx_mask_reg) && !(tx_flag_reg && !tx_mask_reg)
		|=> !interrupt_output_o) else $error("init mask leak");
	AST_IRQ: assert property (summary_w && gie_reg |=> interrupt_output_o)
		else $error("interrupt not raised");
	AST_SET_WINS: assert property (rx_last_desc_wr_i && !srst_w && !stop_w |=>
		rx_flag_reg) else $error("rx event lost");
	AST_CLR_OWN: assert property (st_reg == SC_EVAL && own_q_reg && !sop_q_reg
		&& !srst_w && !stop_w |=> desc_clr_own_o) else $error("own not cleared");
	AST_HOLD: assert property (s_eval_own_sop |=> s_hold_wait ##1
		(s_hold_wait or $past(frame_start_i))) else $error("hold not kept");
	AST_POLL: assert property (st_reg == SC_EVAL && !own_q_reg && sop_q_reg
		&& !srst_w && !stop_w |=> st_reg == SC_POLL) else $error("poll not entered");
	AST_BM16: assert property (bm_addr_valid_i && !software_struct_32bit_o |=>
		bm_addr_o[31:24] == $past(high_byte_w)) else $error("high byte not prepended");
	AST_BM32: assert property (bm_addr_valid_i && software_struct_32bit_o |=>
		bm_addr_o == $past(bm_addr_raw_i)) else $error("32-bit address altered");
	AST_WRAP: assert property (st_reg == SC_EVAL && !own_q_reg && !sop_q_reg
		&& idx_reg == ring_last_i && !srst_w && !stop_w |=> ring_index_o == '0)
		else $error("ring did not wrap");
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "regs_cfg.svh"
module tb_top;
	// ****************************************
	// signals
	// ****************************************
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, raw, bma, ia;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic rx_first, rx_last, tx_done, init_done, irq, ss32, lap, dx2pd, mbo;
	logic raw_v, bma_v, rd_req, rd_done, own, sop, clr_own, wr_done, hold, frame;
	logic [6:0] ring_last, idx;
	int error_cnt, checks;

	// short poll period keeps the host-held marker case quick
	init_addr_and_interrupt_mask_regs #(.RING_AW(7), .POLL_CYC(4)) u_dut (
		.ref_clk_i(clk), .rst_n_i(rst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.rx_first_desc_wr_i(rx_first), .rx_last_desc_wr_i(rx_last), .tx_done_i(tx_done),
		.init_done_i(init_done), .interrupt_output_o(irq), .init_block_address_o(ia),
		.software_struct_32bit_o(ss32), .lookahead_enable_o(lap),
		.disable_two_part_deferral_o(dx2pd), .modified_backoff_enable_o(mbo),
		.bm_addr_raw_i(raw), .bm_addr_valid_i(raw_v), .bm_addr_o(bma),
		.bm_addr_valid_o(bma_v), .ring_last_i(ring_last), .ring_index_o(idx),
		.desc_rd_req_o(rd_req), .desc_rd_done_i(rd_done), .desc_own_i(own),
		.desc_sop_i(sop), .desc_clr_own_o(clr_own), .desc_wr_done_i(wr_done),
		.scan_hold_o(hold), .frame_start_i(frame)
	);

	// ****************************************
	// helpers
	// ****************************************
	task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp1(input string n, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// master never assumes a latency: it waits for bvalid under a bound
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 100) begin
			@(posedge clk);
			n++;
			if (bvalid === 1'b1) break;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		cmp1("bvalid", 1'b1, bvalid);
		cmp32("bresp", {30'h0, er}, {30'h0, bresp});
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 100) begin
			@(posedge clk);
			n++;
			if (rvalid === 1'b1) break;
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		cmp1("rvalid", 1'b1, rvalid);
		cmp32($sformatf("rdata %h", a), e, rdata);
		cmp32("rresp", {30'h0, er}, {30'h0, rresp});
		rready <= 1'b0;
	endtask
	task automatic ev(input int k);
		@(posedge clk);
		case (k)
			0: rx_last <= 1'b1;
			1: tx_done <= 1'b1;
			2: init_done <= 1'b1;
			3: rx_first <= 1'b1;
			default: frame <= 1'b1;
		endcase
		@(posedge clk);
		{rx_last, tx_done, init_done, rx_first, frame} <= 5'h00;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic fix(input logic [31:0] r, input logic [31:0] e);
		@(posedge clk);
		raw <= r;
		raw_v <= 1'b1;
		@(posedge clk);
		raw_v <= 1'b0;
		@(negedge clk);
		cmp1("bm valid", 1'b1, bma_v);
		cmp32("bm addr", e, bma);
	endtask
	// answers one descriptor read; idle lines show the inverse so stale values never pass
	task automatic desc(input logic [6:0] i, input logic o, input logic s, input logic c);
		int n;
		n = 0;
		@(negedge clk);
		while (rd_req !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		cmp1("rd req", 1'b1, rd_req);
		cmp32("index", {25'h0, i}, {25'h0, idx});
		@(posedge clk);
		rd_done <= 1'b1;
		own <= o;
		sop <= s;
		@(posedge clk);
		rd_done <= 1'b0;
		own <= ~o;
		sop <= ~s;
		repeat (2) @(posedge clk);
		@(negedge clk);
		cmp1("clr own", c, clr_own);
		if (c) begin
			@(posedge clk);
			wr_done <= 1'b1;
			@(posedge clk);
			wr_done <= 1'b0;
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rd(`ADR_MASK, 32'h600, `RESP_OKAY);
		rd(`ADR_STATUS, 32'h0, `RESP_OKAY);
		cmp1("irq", 1'b0, irq);
		$display("test reset done");
	endtask
	task automatic t_init;
		wr(`ADR_INIT_LO, 32'h1234, `RESP_OKAY);
		rd(`ADR_LO_ALIAS, 32'h1234, `RESP_OKAY);
		wr(`ADR_LO_ALIAS, 32'h5678, `RESP_OKAY);
		rd(`ADR_INIT_LO, 32'h5678, `RESP_OKAY);
		wr(`ADR_INIT_HI, 32'hab56, `RESP_OKAY);
		rd(`ADR_HI_ALIAS, 32'hab56, `RESP_OKAY);
		rd(`ADR_INIT_HI, 32'hab56, `RESP_OKAY);
		cmp32("init addr", 32'hab565678, ia);
		fix(32'h11abcdef, 32'hababcdef);
		wr(`ADR_CTRL, 32'h4, `RESP_OKAY);
		cmp1("ss32", 1'b1, ss32);
		fix(32'h11abcdef, 32'h11abcdef);
		wr(`ADR_CTRL, 32'h2, `RESP_OKAY);
		rd(`ADR_INIT_LO, 32'h5678, `RESP_OKAY);
		rd(`ADR_INIT_HI, 32'hab56, `RESP_OKAY);
		rd(`ADR_MASK, 32'h0, `RESP_OKAY);
		$display("test init done");
	endtask
	task automatic t_mask;
		wr(`ADR_MASK, 32'h1f78, `RESP_OKAY);
		rd(`ADR_MASK, 32'h738, `RESP_OKAY);
		cmp1("lookahead", 1'b1, lap);
		cmp1("deferral", 1'b1, dx2pd);
		cmp1("backoff", 1'b1, mbo);
		wr(`ADR_CTRL, 32'h1, `RESP_OKAY);
		rd(`ADR_MASK, 32'h738, `RESP_OKAY);
		wr(8'h20, 32'h0, `RESP_SLVERR);
		rd(8'h20, 32'h0, `RESP_SLVERR);
		wr(`ADR_CTRL, 32'h2, `RESP_OKAY);
		rd(`ADR_MASK, 32'h0, `RESP_OKAY);
		cmp1("backoff", 1'b0, mbo);
		$display("test mask done");
	endtask
	task automatic t_irq;
		logic [31:0] b;
		wr(`ADR_CTRL, 32'h8, `RESP_OKAY);
		for (int k = 0; k < 3; k++) begin
			b = 32'h400 >> k;
			wr(`ADR_MASK, b, `RESP_OKAY);
			ev(k);
			cmp1("irq masked", 1'b0, irq);
			rd(`ADR_STATUS, b, `RESP_OKAY);
			wr(`ADR_STATUS, 32'h0, `RESP_OKAY);
			rd(`ADR_STATUS, b, `RESP_OKAY);
			wr(`ADR_STATUS, b, `RESP_OKAY);
			wr(`ADR_MASK, 32'h0, `RESP_OKAY);
			ev(k);
			cmp1("irq", 1'b1, irq);
			rd(`ADR_STATUS, b | 32'h80, `RESP_OKAY);
			wr(`ADR_STATUS, b, `RESP_OKAY);
			rd(`ADR_STATUS, 32'h0, `RESP_OKAY);
			cmp1("irq cleared", 1'b0, irq);
		end
		$display("test irq done");
	endtask
	task automatic t_scan;
		wr(`ADR_MASK, 32'h20, `RESP_OKAY);
		ev(3);
		rd(`ADR_STATUS, 32'h480, `RESP_OKAY);
		wr(`ADR_STATUS, 32'h400, `RESP_OKAY);
		ev(0);
		desc(7'd1, 1'b1, 1'b0, 1'b1);
		desc(7'd2, 1'b0, 1'b0, 1'b0);
		desc(7'd3, 1'b0, 1'b1, 1'b0);
		desc(7'd3, 1'b0, 1'b0, 1'b0);
		desc(7'd0, 1'b1, 1'b1, 1'b0);
		cmp1("hold", 1'b1, hold);
		cmp32("hold index", 32'h0, {25'h0, idx});
		ev(4);
		cmp1("hold released", 1'b0, hold);
		rd(`ADR_STATUS, 32'h480, `RESP_OKAY);
		$display("test scan done");
	endtask
	// second hardware reset in mid-run: init storage survives, masks return to defaults
	task automatic t_hwreset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd(`ADR_INIT_LO, 32'h5678, `RESP_OKAY);
		rd(`ADR_INIT_HI, 32'hab56, `RESP_OKAY);
		rd(`ADR_MASK, 32'h600, `RESP_OKAY);
		rd(`ADR_STATUS, 32'h0, `RESP_OKAY);
		cmp32("init addr", 32'hab565678, ia);
		cmp1("irq", 1'b0, irq);
		$display("test hwreset done");
	endtask

	// ****************************************
	// run
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{rx_first, rx_last, tx_done, init_done, raw_v, rd_done, own, sop} = 8'h00;
		{wr_done, frame} = 2'h0;
		{awaddr, araddr, wdata, raw} = '0;
		wstrb = 4'hf;
		ring_last = 7'd3;
		error_cnt = 0;
		checks = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset;
		t_init;
		t_mask;
		t_irq;
		t_scan;
		t_hwreset;
		conclude;
	end
	// whole run is a few hundred cycles; 20000 leaves ample margin
	initial begin
		#500000;
		error_cnt++;
		$display("watchdog expired");
		conclude;
	end
endmodule
`default_nettype wire
